// ===== design/fps_flash_status.sv
// Functional notes
// [RULE1] programmer waits 20 us before status read
// [RULE2] status byte encodes six error flags
// [RULE3] status bits 2 and 3 undefined
// [RULE4] line 7 shows operation running or done; here line 7 goes high only on a normal end, not on an abnormal end
// [RULE5] line 6 shows normal or abnormal end
// [RULE6] polling lines low while busy, fixed encodings
// [RULE7] commands ignored during stabilization and setup
// [RULE8] after setup enter read mode, accept commands
// [RULE9] programmer erases before reprogramming
// [RULE10] erase recommended after on-board programming
// [RULE11] program each block only once
// [RULE12] polling lines held until next command
// [RULE13] no command writes during auto-erase
// [RULE14] new program/erase clears error bits
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "fps_params.svh"
module fps_flash_status import fps_pkg::*; #(
  parameter int unsigned OSC_CYC = `FPS_OSC_CYC,
  parameter int unsigned SETUP_CYC = `FPS_SETUP_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic opStart,
  output logic opErase,
  input wire logic opDone,
  input wire logic [7:0] opFaults,
  output logic irq
);
  typedef struct packed {
    fps_mode_t mode;
    logic [31:0] cnt;
    logic [7:0] status;
    logic completionFlagLine;
    logic resultFlagLine;
    logic eraseRun;
    logic opStart;
    logic opErase;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic wStrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic irq;
    logic awReady;
    logic wReady;
    logic arReady;
  } fps_state_t;

  fps_state_t s, next_s;
  logic doWrite, doRead, cmdWrite;
  logic [7:0] cmd;
  logic [1:0] evt;

  assign doWrite = s.awHeld && s.wHeld && !s.bvalid;
  assign doRead = arvalid && !s.rvalid;
  assign cmd = s.wData[7:0];
  // commands only take effect in read or status mode, never while busy
  assign cmdWrite = doWrite && s.awAddr == `FPS_OFF_CMD && s.wStrb0 &&
    (s.mode == FPS_READ || s.mode == FPS_STATUS); // see [RULE7]

  // next-state logic
  always_comb begin
    next_s = s;
    evt = 2'h0;
    next_s.opStart = 1'b0;
    if (!s.awHeld && awvalid) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (!s.wHeld && wvalid) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb0 = wstrb[0];
    end
    case (s.mode)
      FPS_OSC: begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt >= OSC_CYC - 1) begin // see [RULE7]
          next_s.mode = FPS_SETUP;
          next_s.cnt = 32'h0;
        end
      end
      FPS_SETUP: begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt >= SETUP_CYC - 1) begin
          next_s.mode = FPS_READ; // see [RULE8]
          evt[`FPS_IRQ_READY] = 1'b1;
        end
      end
      FPS_BUSY: begin
        if (opDone) begin
          // abnormal end: any fault from the array engine
          next_s.status[`FPS_BIT_ABNORMAL] = |opFaults;
          next_s.status[`FPS_BIT_PROG_ERR] = opFaults[`FPS_BIT_PROG_ERR];
          next_s.status[`FPS_BIT_ERASE_ERR] = opFaults[`FPS_BIT_ERASE_ERR];
          next_s.status[`FPS_BIT_CYCLE_LIM] = opFaults[`FPS_BIT_CYCLE_LIM];
          next_s.status[`FPS_BIT_BAD_ADDR] = opFaults[`FPS_BIT_BAD_ADDR]; // see [RULE2]
          next_s.completionFlagLine = ~|opFaults; // see [RULE4]
          next_s.resultFlagLine = |opFaults; // see [RULE5] see [RULE6]
          next_s.eraseRun = 1'b0;
          next_s.mode = FPS_READ;
          evt[`FPS_IRQ_DONE] = 1'b1;
        end
      end
      default: ;
    endcase
    if (cmdWrite) begin
      // a new command write drops the held polling info
      next_s.completionFlagLine = 1'b0; // see [RULE12]
      next_s.resultFlagLine = 1'b0;
      case (cmd)
        `FPS_CMD_PROGRAM, `FPS_CMD_ERASE: begin
          next_s.status = `FPS_STATUS_RESET; // see [RULE14]
          next_s.mode = FPS_BUSY;
          next_s.opStart = 1'b1;
          next_s.opErase = cmd == `FPS_CMD_ERASE;
          next_s.eraseRun = cmd == `FPS_CMD_ERASE; // see [RULE13]
        end
        `FPS_CMD_STATUS: next_s.mode = FPS_STATUS;
        `FPS_CMD_READ: next_s.mode = FPS_READ;
        default: begin
          next_s.status[`FPS_BIT_CMD_ERR] = 1'b1; // see [RULE2]
          next_s.status[`FPS_BIT_ABNORMAL] = 1'b1;
        end
      endcase
    end
    // write response and register side effects
    if (doWrite) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = 2'h0;
      case (s.awAddr)
        `FPS_OFF_CMD: ;
        `FPS_OFF_IRQ_STAT: next_s.irqStat = s.irqStat & ~s.wData[1:0];
        `FPS_OFF_IRQ_MASK: next_s.irqMask = s.wData[1:0];
        default: next_s.bresp = 2'h2;
      endcase
    end
    if (s.bvalid && bready) next_s.bvalid = 1'b0;
    // set wins over write-one-to-clear
    next_s.irqStat = next_s.irqStat | evt;
    if (doRead) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = 2'h0;
      case (araddr)
        // bits 3:2 read as zero; software must ignore them
        `FPS_OFF_STATUS: next_s.rdata = {24'h0, s.status}; // see [RULE3]
        `FPS_OFF_POLL: next_s.rdata = {24'h0, s.completionFlagLine, s.resultFlagLine, 6'h00};
        `FPS_OFF_MODE: next_s.rdata = {29'h0, s.mode};
        `FPS_OFF_IRQ_STAT: next_s.rdata = {30'h0, s.irqStat};
        `FPS_OFF_IRQ_MASK: next_s.rdata = {30'h0, s.irqMask};
        `FPS_OFF_RESULT: next_s.rdata = {31'h0, s.eraseRun};
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = 2'h2;
        end
      endcase
    end
    if (s.rvalid && rready) next_s.rvalid = 1'b0;
    next_s.irq = |(next_s.irqStat & next_s.irqMask);
    // ready flags registered so no bus output passes through a gate
    next_s.awReady = !next_s.awHeld;
    next_s.wReady = !next_s.wHeld;
    next_s.arReady = !next_s.rvalid;
  end

  // state register, synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.mode <= FPS_OSC;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awReady;
  assign wready = s.wReady;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arReady;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign opStart = s.opStart;
  assign opErase = s.opErase;
  assign irq = s.irq;

  chk_busy_lines_low: assert property (@(posedge clock) disable iff (rst)
    s.mode == FPS_BUSY |-> !s.completionFlagLine && !s.resultFlagLine) // see [RULE6]
    else $error("polling lines not low while busy");
  chk_no_cmd_early: assert property (@(posedge clock) disable iff (rst)
    (s.mode == FPS_OSC || s.mode == FPS_SETUP) |=> s.mode != FPS_BUSY) // see [RULE7]
    else $error("command accepted during setup");
  chk_setup_to_read: assert property (@(posedge clock) disable iff (rst)
    s.mode == FPS_SETUP && s.cnt >= SETUP_CYC - 1 |=> s.mode == FPS_READ) // see [RULE8]
    else $error("no read mode after setup");
  chk_done_flags: assert property (@(posedge clock) disable iff (rst)
    s.mode == FPS_BUSY && opDone && !cmdWrite |=>
      s.completionFlagLine == ~s.resultFlagLine && s.resultFlagLine == s.status[7]) // see [RULE4]
    else $error("completion flag wrong");
  chk_result_abnormal: assert property (@(posedge clock) disable iff (rst)
    s.mode == FPS_BUSY && opDone && opFaults != 8'h00 |=>
      s.resultFlagLine && !s.completionFlagLine) // see [RULE5]
    else $error("result flag wrong");
  chk_poll_hold: assert property (@(posedge clock) disable iff (rst)
    s.mode == FPS_READ && !cmdWrite |=> $stable(s.completionFlagLine)) // see [RULE12]
    else $error("polling info lost");
  chk_start_clears: assert property (@(posedge clock) disable iff (rst)
    cmdWrite && (cmd == `FPS_CMD_PROGRAM || cmd == `FPS_CMD_ERASE) |=>
      s.status == 8'h00 ##1 s.opStart == 1'b0) // see [RULE14]
    else $error("status not cleared on start");
  chk_cmd_error: assert property (@(posedge clock) disable iff (rst)
    cmdWrite && cmd != `FPS_CMD_PROGRAM && cmd != `FPS_CMD_ERASE &&
      cmd != `FPS_CMD_STATUS && cmd != `FPS_CMD_READ |=> s.status[6] && s.status[7]) // see [RULE2]
    else $error("command error not flagged");
  cov_program: cover property (@(posedge clock) disable iff (rst)
    cmdWrite && cmd == `FPS_CMD_PROGRAM);
  cov_erase_done: cover property (@(posedge clock) disable iff (rst)
    s.eraseRun && opDone);
  cov_status_read: cover property (@(posedge clock) disable iff (rst)
    doRead && araddr == `FPS_OFF_STATUS);
endmodule

// ===== dv/fps_array_model.sv
`timescale 1ns/1ns
module fps_array_model #(
  parameter int unsigned DELAY = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic opStart,
  input wire logic [7:0] faultSet,
  output logic opDone,
  output logic [7:0] opFaults
);
  int cnt;
  // one done pulse per start, after a fixed busy time
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt <= 0;
      opDone <= 1'b0;
    end else begin
      opDone <= (cnt == 1);
      if (opStart) cnt <= DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
  // faults only meaningful with done; inverted otherwise to catch early sampling
  assign opFaults = opDone ? faultSet : ~faultSet;
endmodule

// ===== dv/tb_fps_flash_status.sv
`timescale 1ns/1ns
`include "fps_params.svh"
module tb_fps_flash_status import fps_pkg::*;;
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, opStart, opErase, opDone, irq;
  logic [7:0] awaddr, araddr, opFaults, faultSet;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lastResp;
  int num_errors = 0, samples_checked = 0, starts = 0, cycles = 0;
  logic [7:0] faults [4] = '{8'h20, 8'h10, 8'h02, 8'h01};
  fps_flash_status #(.OSC_CYC(4), .SETUP_CYC(4)) dut (.clock(clock), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .opStart(opStart), .opErase(opErase),
    .opDone(opDone), .opFaults(opFaults), .irq(irq));
  fps_array_model #(.DELAY(20)) engine (.clock(clock), .rst(rst), .opStart(opStart),
    .faultSet(faultSet), .opDone(opDone), .opFaults(opFaults));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // start counter and hang guard
  always @(posedge clock) begin
    if (opStart === 1'b1) starts++;
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    lastResp = rresp;
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    rd(a, d);
    chk(nm, e, d & m);
  endtask
  // poll until either flag line shows an end, bounded
  task automatic waitop();
    int n;
    n = 0;
    do begin
      rd(`FPS_OFF_POLL, d);
      n++;
    end while (d[7:6] == 2'b00 && n < 40);
    chk("op end", 32'h1, 32'(d[7:6] != 2'b00));
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, faultSet} = '0;
    wstrb = 4'hF;
    rst = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wr(`FPS_OFF_CMD, `FPS_CMD_PROGRAM, 2'b00);
    chk("starts", 0, starts);
    repeat (12) @(posedge clock);
    rchk("mode", `FPS_OFF_MODE, 32'(FPS_READ));
    rchk("irqstat", `FPS_OFF_IRQ_STAT, 32'h2);
    chk("irq masked", 0, 32'(irq));
    wr(`FPS_OFF_IRQ_MASK, 32'h1, 2'b00);
    wr(`FPS_OFF_IRQ_STAT, 32'h3, 2'b00);
    $display("test startup done");
    wr(`FPS_OFF_CMD, `FPS_CMD_ERASE, 2'b00);
    chk("op erase", 32'h1, 32'(opErase));
    rchk("poll busy", `FPS_OFF_POLL, 32'h0);
    rchk("mode busy", `FPS_OFF_MODE, 32'(FPS_BUSY));
    rchk("erasing", `FPS_OFF_RESULT, 32'h1);
    waitop();
    rchk("poll end", `FPS_OFF_POLL, 32'h80);
    rchk("poll held", `FPS_OFF_POLL, 32'h80);
    chk("irq", 1, 32'(irq));
    wr(`FPS_OFF_IRQ_STAT, 32'h1, 2'b00);
    rchk("irqstat", `FPS_OFF_IRQ_STAT, 32'h0);
    chk("irq clr", 0, 32'(irq));
    $display("test erase done");
    // each fault alone, each program once per block
    foreach (faults[i]) begin
      faultSet <= faults[i];
      wr(`FPS_OFF_CMD, `FPS_CMD_PROGRAM, 2'b00);
      chk("op program", 32'h0, 32'(opErase));
      waitop();
      rchk("poll abn", `FPS_OFF_POLL, 32'h40);
      rchk("status", `FPS_OFF_STATUS, 32'h80 | faults[i], 32'hF3);
    end
    faultSet <= 8'h00;
    wr(`FPS_OFF_CMD, `FPS_CMD_PROGRAM, 2'b00);
    waitop();
    rchk("status clr", `FPS_OFF_STATUS, 32'h0, 32'hF3);
    $display("test faults done");
    wr(`FPS_OFF_CMD, 32'h55, 2'b00);
    rchk("cmd err", `FPS_OFF_STATUS, 32'hC0, 32'hF3);
    wr(`FPS_OFF_CMD, `FPS_CMD_STATUS, 2'b00);
    repeat (5000) @(posedge clock);
    rchk("mode status", `FPS_OFF_MODE, 32'(FPS_STATUS));
    rchk("status", `FPS_OFF_STATUS, 32'hC0, 32'hF3);
    $display("test commands done");
    wr(8'h40, 32'h0, 2'b10);
    rchk("unmapped", 8'h40, 32'h0);
    chk("rresp", 32'h2, 32'(lastResp));
    // one erase and five programs, each a single start pulse
    chk("starts", 32'h6, starts);
    $display("test unmapped done");
    summarize();
  end
endmodule

// ===== include/fps_params.svh
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH
// axi4-lite byte offsets
`define FPS_OFF_CMD 8'h00
`define FPS_OFF_STATUS 8'h04
`define FPS_OFF_POLL 8'h08
`define FPS_OFF_MODE 8'h0C
`define FPS_OFF_IRQ_STAT 8'h10
`define FPS_OFF_IRQ_MASK 8'h14
`define FPS_OFF_RESULT 8'h18
// status byte bit positions
`define FPS_BIT_ABNORMAL 7
`define FPS_BIT_CMD_ERR 6
`define FPS_BIT_PROG_ERR 5
`define FPS_BIT_ERASE_ERR 4
`define FPS_BIT_CYCLE_LIM 1
`define FPS_BIT_BAD_ADDR 0
// command codes written to the command register
`define FPS_CMD_READ 8'h00
`define FPS_CMD_PROGRAM 8'h40
`define FPS_CMD_ERASE 8'h20
`define FPS_CMD_STATUS 8'h71
// irq bits
`define FPS_IRQ_DONE 0
`define FPS_IRQ_READY 1
// times
`define FPS_CLK_MHZ 250
`define FPS_OSC_MS 10
`define FPS_SETUP_MS 10
`define FPS_OSC_CYC (`FPS_OSC_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_SETUP_CYC (`FPS_SETUP_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_STATUS_RESET 8'h00
`endif

// ===== include/fps_pkg.sv
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_OSC = 3'b000,
    FPS_SETUP = 3'b001,
    FPS_READ = 3'b011,
    FPS_BUSY = 3'b010,
    FPS_STATUS = 3'b110
  } fps_mode_t;
endpackage
